// [bench/address_map_port_access_tb_top.sv]
/*
  Testbench for the address map and port access bridge: register and memory accesses with expected results.
  Assumes the core model in ampa_core_model and the bridge in ampa_bridge.
*/
`timescale 1ns/1ps
module address_map_port_access_tb_top;
  import ampa_pkg::*;
  localparam logic [1:0] K_RD = 2'h0;
  localparam logic [1:0] K_WR = 2'h1;
  localparam logic [1:0] K_FE = 2'h2;
  localparam logic [1:0] DN   = 2'h1;
  localparam logic [1:0] ER   = 2'h2;
  logic            core_clk_in;
  logic            rst_n_in;
  logic [31:0]     cpu_addr_in;
  logic [7:0]      cpu_wdata_in;
  logic [1:0]      cpu_size_in;
  logic            cpu_rd_in;
  logic            cpu_wr_in;
  logic            cpu_fetch_in;
  ampa_mode_t      op_mode_in;
  logic [2:0]      rom_cap_sel_in;
  logic [2:0]      ram_cap_sel_in;
  logic [2:0]      peri_div_in;
  logic [17:0][7:0] pin_level_in;
  logic [7:0]      cpu_rdata_out;
  logic            cpu_done_out;
  logic            cpu_err_out;
  logic            cpu_busy_out;
  logic            rom_sel_out;
  logic            ram_sel_out;
  logic [31:0]     mem_offset_out;
  logic [1:0][7:0] pin_func_out;
  int              fail_count;
  int              check_count;
  int              cyc_count;

  ampa_bridge ampa_bridge_i (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cpu_addr_in(cpu_addr_in),
    .cpu_wdata_in(cpu_wdata_in), .cpu_size_in(cpu_size_in), .cpu_rd_in(cpu_rd_in), .cpu_wr_in(cpu_wr_in),
    .cpu_fetch_in(cpu_fetch_in), .op_mode_in(op_mode_in), .rom_cap_sel_in(rom_cap_sel_in),
    .ram_cap_sel_in(ram_cap_sel_in), .peri_div_in(peri_div_in), .pin_level_in(pin_level_in),
    .cpu_rdata_out(cpu_rdata_out), .cpu_done_out(cpu_done_out), .cpu_err_out(cpu_err_out),
    .cpu_busy_out(cpu_busy_out), .rom_sel_out(rom_sel_out), .ram_sel_out(ram_sel_out),
    .mem_offset_out(mem_offset_out), .pin_func_out(pin_func_out));

  ampa_core_model ampa_core_model_i (.clk_in(core_clk_in), .done_in(cpu_done_out), .err_in(cpu_err_out),
    .rdata_in(cpu_rdata_out), .sel_in({rom_sel_out, ram_sel_out}), .addr_out(cpu_addr_in),
    .wdata_out(cpu_wdata_in), .size_out(cpu_size_in), .rd_out(cpu_rd_in), .wr_out(cpu_wr_in),
    .fetch_out(cpu_fetch_in));

  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge core_clk_in)
  begin
    cyc_count++;
    if (cyc_count == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string msg);
    check_count++;
    if (got < lo || got > hi)
    begin
      fail_count++;
      $display("[FAIL] %0t %s took %0d not %0d..%0d", $time, msg, got, lo, hi);
    end
  endtask

  task automatic acc(input logic [1:0] kind, input logic [31:0] a, input logic [1:0] sz, input logic [7:0] wd,
                     input logic [1:0] est, input logic [7:0] eq, input int lo, input int hi, input logic [1:0] esel);
    logic [7:0] q;
    logic [1:0] st;
    logic [1:0] sel;
    int         cyc;
    ampa_core_model_i.xfer(kind, a, sz, wd, q, st, sel, cyc);
    chk_val(32'(st), 32'(est), "answer kind");
    chk_val(32'(sel), 32'(esel), "memory select");
    chk_rng(cyc, lo, hi, "latency");
    if (st == DN)
      chk_val(32'(q), 32'(eq), "read data");
  endtask

  initial
  begin
    fail_count = 0;
    check_count = 0;
    cyc_count = 0;
    rst_n_in = 1'b0;
    op_mode_in = AMPA_MODE_SINGLE;
    rom_cap_sel_in = 3'h0;
    ram_cap_sel_in = 3'h0;
    peri_div_in = 3'h0;
    for (int i = 0; i < 18; i++)
      pin_level_in[i] = 8'hA5 ^ 8'(i);
    repeat (8) @(posedge core_clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    acc(K_RD, AMPA_CTRL_ADDR, AMPA_SIZE_BYTE, 8'h00, DN, 8'h03, 2, 2, 2'h0);
    acc(K_RD, AMPA_STAT_ADDR, AMPA_SIZE_BYTE, 8'h00, DN, 8'h00, 2, 2, 2'h0);
    acc(K_RD, AMPA_PIN_FUNC_ADDR[1], AMPA_SIZE_BYTE, 8'h00, DN, 8'h00, 2, 2, 2'h0);
    $display("reset values test done");
    for (int s = 0; s < 8; s++)
    begin
      rom_cap_sel_in <= 3'(s);
      acc(K_RD, AMPA_ROM_BASE[s], AMPA_SIZE_LONG, 8'h00, DN, 8'h00, 1, 1, 2'h2);
      chk_val(mem_offset_out, 32'h0000_0000, "rom offset");
      acc(K_RD, AMPA_ROM_BASE[s] - 32'h0000_0001, AMPA_SIZE_BYTE, 8'h00, ER, 8'h00, 1, 1, 2'h0);
    end
    acc(K_FE, 32'hFFFF_FFFF, AMPA_SIZE_BYTE, 8'h00, DN, 8'h00, 1, 1, 2'h2);
    chk_val(mem_offset_out, 32'h0000_FFFF, "top offset");
    acc(K_WR, AMPA_ROM_BASE[7], AMPA_SIZE_BYTE, 8'h11, ER, 8'h00, 1, 1, 2'h0);
    for (int s = 0; s < 6; s++)
    begin
      ram_cap_sel_in <= 3'(s);
      acc(K_RD, AMPA_RAM_LIMIT[s] - 32'h0000_0001, AMPA_SIZE_WORD, 8'h00, DN, 8'h00, 1, 1, 2'h1);
      chk_val(mem_offset_out, AMPA_RAM_LIMIT[s] - 32'h0000_0001, "ram offset");
      acc(K_WR, AMPA_RAM_LIMIT[s], AMPA_SIZE_BYTE, 8'h22, ER, 8'h00, 1, 1, 2'h0);
    end
    ram_cap_sel_in <= 3'h6;
    acc(K_RD, 32'h0000_0000, AMPA_SIZE_BYTE, 8'h00, ER, 8'h00, 1, 1, 2'h0);
    ram_cap_sel_in <= 3'h0;
    acc(K_RD, 32'h0008_C050, AMPA_SIZE_BYTE, 8'h00, ER, 8'h00, 1, 1, 2'h0);
    $display("memory map test done");
    for (int m = 0; m < 3; m++)
    begin
      op_mode_in <= ampa_mode_t'(m);
      acc(K_FE, 32'h0000_0000, AMPA_SIZE_LONG, 8'h00, DN, 8'h00, 1, 1, 2'h1);
      acc(K_FE, AMPA_PIN_LEVEL_ADDR[0], AMPA_SIZE_BYTE, 8'h00, DN, 8'hA5, 3, 3, 2'h0);
    end
    $display("mode test done");
    for (int i = 0; i < 18; i++)
    begin
      int lat;
      lat = (i < AMPA_SHORT_FIRST) ? 3 : 2;
      acc(K_RD, AMPA_PIN_LEVEL_ADDR[i], AMPA_SIZE_BYTE, 8'h00, DN, 8'hA5 ^ 8'(i), lat, lat, 2'h0);
    end
    acc(K_WR, AMPA_PIN_LEVEL_ADDR[0], AMPA_SIZE_BYTE, 8'h3C, DN, 8'h00, 2, 2, 2'h0);
    acc(K_RD, AMPA_PIN_LEVEL_ADDR[0], AMPA_SIZE_BYTE, 8'h00, DN, 8'hA5, 3, 3, 2'h0);
    for (int f = 0; f < 2; f++)
    begin
      acc(K_WR, AMPA_PIN_FUNC_ADDR[f], AMPA_SIZE_BYTE, 8'h5A ^ 8'(f), DN, 8'h00, 2, 2, 2'h0);
      chk_val(32'(pin_func_out[f]), 32'(8'h5A ^ 8'(f)), "function output");
      acc(K_RD, AMPA_PIN_FUNC_ADDR[f], AMPA_SIZE_BYTE, 8'h00, DN, 8'h5A ^ 8'(f), 2, 2, 2'h0);
    end
    $display("port register test done");
    acc(K_RD, AMPA_PIN_LEVEL_ADDR[3], AMPA_SIZE_WORD, 8'h00, ER, 8'h00, 1, 1, 2'h0);
    acc(K_WR, AMPA_PIN_FUNC_ADDR[0], AMPA_SIZE_LONG, 8'hFF, ER, 8'h00, 1, 1, 2'h0);
    chk_val(32'(pin_func_out[0]), 32'h0000_005A, "refused write kept out");
    acc(K_RD, AMPA_STAT_ADDR, AMPA_SIZE_BYTE, 8'h00, DN, 8'h01, 2, 2, 2'h0);
    acc(K_WR, AMPA_STAT_ADDR, AMPA_SIZE_BYTE, 8'h01, DN, 8'h00, 2, 2, 2'h0);
    acc(K_RD, AMPA_STAT_ADDR, AMPA_SIZE_BYTE, 8'h00, DN, 8'h00, 2, 2, 2'h0);
    acc(K_WR, AMPA_CTRL_ADDR, AMPA_SIZE_BYTE, 8'h00, DN, 8'h00, 2, 2, 2'h0);
    acc(K_RD, 32'h0000_0010, AMPA_SIZE_BYTE, 8'h00, ER, 8'h00, 1, 1, 2'h0);
    acc(K_FE, 32'hFFFF_FFF0, AMPA_SIZE_LONG, 8'h00, ER, 8'h00, 1, 1, 2'h0);
    acc(K_WR, AMPA_CTRL_ADDR, AMPA_SIZE_BYTE, 8'h03, DN, 8'h00, 2, 2, 2'h0);
    acc(K_RD, 32'h0000_0010, AMPA_SIZE_BYTE, 8'h00, DN, 8'h00, 1, 1, 2'h1);
    $display("refusal and enable test done");
    for (int k = 1; k < 8; k += 3)
    begin
      peri_div_in <= 3'(k);
      acc(K_RD, AMPA_PIN_LEVEL_ADDR[5], AMPA_SIZE_BYTE, 8'h00, DN, 8'hA0, 3, 3 * k, 2'h0);
      acc(K_WR, AMPA_PIN_LEVEL_ADDR[5], AMPA_SIZE_BYTE, 8'h77, DN, 8'h00, 2, 2 * k, 2'h0);
      acc(K_RD, AMPA_PIN_LEVEL_ADDR[17], AMPA_SIZE_BYTE, 8'h00, DN, 8'hB4, 2, 2 * k, 2'h0);
      acc(K_RD, AMPA_PIN_FUNC_ADDR[1], AMPA_SIZE_BYTE, 8'h00, DN, 8'h5B, 2, 2 * k, 2'h0);
    end
    $display("peripheral rate test done");
    close_out();
  end
endmodule

// [bench/ampa_core_model.sv]
/*
  Processor core model: issues one read, write or fetch at a time and waits for the answer.
  Assumes the bridge answers within 40 core cycles and never stalls a memory hit.
*/
`timescale 1ns/1ps
module ampa_core_model
(
  input  wire logic        clk_in,
  input  wire logic        done_in,
  input  wire logic        err_in,
  input  wire logic [7:0]  rdata_in,
  input  wire logic [1:0]  sel_in,
  output logic      [31:0] addr_out,
  output logic      [7:0]  wdata_out,
  output logic      [1:0]  size_out,
  output logic             rd_out,
  output logic             wr_out,
  output logic             fetch_out
);
  initial
  begin
    addr_out  = 32'h0000_0000;
    wdata_out = 8'h00;
    size_out  = 2'h0;
    rd_out    = 1'b0;
    wr_out    = 1'b0;
    fetch_out = 1'b0;
  end

  task automatic xfer(input logic [1:0] kind, input logic [31:0] a, input logic [1:0] sz, input logic [7:0] wd,
                      output logic [7:0] q, output logic [1:0] st, output logic [1:0] sel, output int cyc);
    cyc = 0;
    st  = 2'h0;
    q   = 8'h00;
    sel = 2'h0;
    @(posedge clk_in);
    addr_out  <= a;
    wdata_out <= wd;
    size_out  <= sz;
    rd_out    <= (kind == 2'h0);
    wr_out    <= (kind == 2'h1);
    fetch_out <= (kind == 2'h2);
    @(posedge clk_in);
    rd_out    <= 1'b0;
    wr_out    <= 1'b0;
    fetch_out <= 1'b0;
    // released lines show the inverse so a stale value cannot pass
    addr_out  <= ~a;
    wdata_out <= ~wd;
    // answers are one-cycle pulses: look first right after the take edge
    while (cyc < 40 && st == 2'h0)
    begin
      #1;
      cyc++;
      st  = {err_in, done_in};
      q   = rdata_in;
      sel = sel_in;
      if (st == 2'h0)
        @(posedge clk_in);
    end
  endtask
endmodule

// [logic/ampa_bridge.sv]
/*
  Address decoder and port register access timer between the processor core
  and the 8-bit port registers. Assumes pin levels are asynchronous, all other
  inputs come from core-clock logic, and one request is outstanding at a time.
*/
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
module ampa_bridge
(
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_n_in,
  input  wire logic [31:0]                 cpu_addr_in,
  input  wire logic [7:0]                  cpu_wdata_in,
  input  wire logic [1:0]                  cpu_size_in,
  input  wire logic                        cpu_rd_in,
  input  wire logic                        cpu_wr_in,
  input  wire logic                        cpu_fetch_in,
  input  wire ampa_pkg::ampa_mode_t        op_mode_in,
  input  wire logic [2:0]                  rom_cap_sel_in,
  input  wire logic [2:0]                  ram_cap_sel_in,
  input  wire logic [2:0]                  peri_div_in,
  input  wire logic [17:0][7:0]            pin_level_in,
  output logic      [7:0]                  cpu_rdata_out,
  output logic                             cpu_done_out,
  output logic                             cpu_err_out,
  output logic                             cpu_busy_out,
  output logic                             rom_sel_out,
  output logic                             ram_sel_out,
  output logic      [31:0]                 mem_offset_out,
  output logic      [1:0][7:0]             pin_func_out
);
  import ampa_pkg::*;

  ampa_state_t                 state_r;
  logic [2:0]                  cnt_r;
  logic [2:0]                  div_cnt_r;
  logic [1:0]                  tgt_kind_r;
  logic [4:0]                  tgt_idx_r;
  logic                        tgt_wr_r;
  logic [7:0]                  wdata_r;
  logic [7:0]                  ctrl_r;
  logic [7:0]                  stat_r;
  logic [1:0][7:0]             pin_func_r;
  logic [17:0][7:0]            pin_meta_r;
  logic [17:0][7:0]            pin_sync_r;
  logic [7:0]                  rdata_r;
  logic                        done_r;
  logic                        err_r;
  logic                        busy_r;
  logic                        rom_sel_r;
  logic                        ram_sel_r;
  logic [31:0]                 offset_r;

  logic                        req_w;
  logic                        take_w;
  logic                        tick_w;
  logic                        finish_w;
  logic                        rom_area_w;
  logic                        rom_hit_w;
  logic                        ram_hit_w;
  logic [AMPA_PORT_NUM-1:0]    pin_hit_w;
  logic [AMPA_FUNC_NUM-1:0]    func_hit_w;
  logic                        ctrl_hit_w;
  logic                        stat_hit_w;
  logic                        reg_hit_w;
  logic                        short_w;
  logic [4:0]                  idx_w;
  logic [1:0]                  kind_w;
  logic [2:0]                  need_w;
  logic [7:0]                  rd_val_w;
  logic                        err_set_w;
  logic                        err_clr_w;

  assign cpu_rdata_out  = rdata_r;
  assign cpu_done_out   = done_r;
  assign cpu_err_out    = err_r;
  assign cpu_busy_out   = busy_r;
  assign rom_sel_out    = rom_sel_r;
  assign ram_sel_out    = ram_sel_r;
  assign mem_offset_out = offset_r;
  assign pin_func_out   = pin_func_r;

  // fetch is treated as a read on the same map, op mode is not looked at
  assign req_w  = cpu_rd_in | cpu_wr_in | cpu_fetch_in;
  assign take_w = req_w && (state_r == AMPA_IDLE);

  // pin levels are asynchronous, two flops before anything reads them
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end
    else
    begin
      pin_meta_r <= pin_level_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // peripheral tick divider; zero means the core clock is the slower one
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      div_cnt_r <= 3'h0;
    else if (div_cnt_r == 3'h0)
      div_cnt_r <= (peri_div_in == 3'h0) ? 3'h0 : peri_div_in - 3'h1;
    else
      div_cnt_r <= div_cnt_r - 3'h1;
  end

  assign tick_w   = (peri_div_in == 3'h0) || (div_cnt_r == 3'h0);
  assign finish_w = (state_r == AMPA_WAIT) && tick_w && (cnt_r == 3'h1);

  // memory regions: full 32-bit compare, the top compare covers up to all ones
  assign rom_area_w = (cpu_addr_in >= AMPA_ROM_BASE[rom_cap_sel_in]);
  assign rom_hit_w  = rom_area_w && ctrl_r[AMPA_CTRL_ROM_EN_BIT];
  assign ram_hit_w  = ctrl_r[AMPA_CTRL_RAM_EN_BIT] && (cpu_addr_in >= AMPA_ADDR_BOTTOM)
                      && (cpu_addr_in < AMPA_RAM_LIMIT[ram_cap_sel_in]);

  genvar gi;
  generate
    for (gi = 0; gi < AMPA_PORT_NUM; gi++)
    begin : g_pin
      assign pin_hit_w[gi] = (cpu_addr_in == AMPA_PIN_LEVEL_ADDR[gi]);
    end
    for (gi = 0; gi < AMPA_FUNC_NUM; gi++)
    begin : g_func
      assign func_hit_w[gi] = (cpu_addr_in == AMPA_PIN_FUNC_ADDR[gi]);
    end
  endgenerate

  assign ctrl_hit_w = (cpu_addr_in == AMPA_CTRL_ADDR);
  assign stat_hit_w = (cpu_addr_in == AMPA_STAT_ADDR);
  assign reg_hit_w  = (|pin_hit_w) || (|func_hit_w) || ctrl_hit_w || stat_hit_w;

  always_comb
  begin
    idx_w   = 5'h0;
    kind_w  = AMPA_TGT_PIN;
    short_w = 1'b1;
    for (int i = 0; i < AMPA_PORT_NUM; i++)
    begin
      if (pin_hit_w[i])
      begin
        idx_w   = 5'(i);
        short_w = (i >= AMPA_SHORT_FIRST);
      end
    end
    for (int j = 0; j < AMPA_FUNC_NUM; j++)
    begin
      if (func_hit_w[j])
      begin
        idx_w  = 5'(j);
        kind_w = AMPA_TGT_FUNC;
      end
    end
    if (ctrl_hit_w)
      kind_w = AMPA_TGT_CTRL;
    if (stat_hit_w)
      kind_w = AMPA_TGT_STAT;
  end

  always_comb
  begin
    if (short_w)
      need_w = AMPA_SHORT_CYC;
    else if (cpu_wr_in)
      need_w = AMPA_PIN_WR_CYC;
    else
      need_w = AMPA_PIN_RD_CYC;
  end

  always_comb
  begin
    case (tgt_kind_r)
      AMPA_TGT_PIN:  rd_val_w = pin_sync_r[tgt_idx_r];
      AMPA_TGT_FUNC: rd_val_w = pin_func_r[tgt_idx_r[0]];
      AMPA_TGT_CTRL: rd_val_w = ctrl_r;
      default:       rd_val_w = stat_r;
    endcase
  end

  // rom write, wide register access, disabled or unmapped address all error
  assign err_set_w = take_w && !((rom_hit_w && !cpu_wr_in) || (ram_hit_w && !rom_area_w)
                     || (reg_hit_w && cpu_size_in == AMPA_SIZE_BYTE));
  assign err_clr_w = finish_w && tgt_wr_r && (tgt_kind_r == AMPA_TGT_STAT) && wdata_r[AMPA_STAT_ERR_BIT];

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_r    <= AMPA_IDLE;
      cnt_r      <= 3'h0;
      tgt_kind_r <= AMPA_TGT_PIN;
      tgt_idx_r  <= 5'h0;
      tgt_wr_r   <= 1'b0;
      wdata_r    <= 8'h00;
      busy_r     <= 1'b0;
    end
    else
    begin
      case (state_r)
        AMPA_IDLE:
        begin
          // requests seen while busy are dropped, the core waits for done
          if (take_w && !err_set_w && reg_hit_w && !rom_hit_w && !ram_hit_w)
          begin
            state_r    <= AMPA_WAIT;
            // the take edge already counts as the first access cycle
            cnt_r      <= need_w - 3'h1;
            tgt_kind_r <= kind_w;
            tgt_idx_r  <= idx_w;
            tgt_wr_r   <= cpu_wr_in;
            wdata_r    <= cpu_wdata_in;
            busy_r     <= 1'b1;
          end
        end
        AMPA_WAIT:
        begin
          if (tick_w)
            cnt_r <= cnt_r - 3'h1;
          if (finish_w)
          begin
            state_r <= AMPA_IDLE;
            busy_r  <= 1'b0;
          end
        end
        default:
        begin
          state_r <= AMPA_IDLE;
          busy_r  <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_r    <= 1'b0;
      err_r     <= 1'b0;
      rom_sel_r <= 1'b0;
      ram_sel_r <= 1'b0;
      offset_r  <= 32'h0000_0000;
      rdata_r   <= 8'h00;
    end
    else
    begin
      done_r    <= 1'b0;
      rom_sel_r <= 1'b0;
      ram_sel_r <= 1'b0;
      err_r     <= err_set_w;
      if (take_w && !err_set_w && rom_hit_w)
      begin
        done_r    <= 1'b1;
        rom_sel_r <= 1'b1;
        offset_r  <= cpu_addr_in - AMPA_ROM_BASE[rom_cap_sel_in];
        rdata_r   <= 8'h00;
      end
      else if (take_w && !err_set_w && ram_hit_w)
      begin
        done_r    <= 1'b1;
        ram_sel_r <= 1'b1;
        offset_r  <= cpu_addr_in;
        rdata_r   <= 8'h00;
      end
      else if (finish_w)
      begin
        done_r  <= 1'b1;
        rdata_r <= tgt_wr_r ? 8'h00 : rd_val_w;
      end
    end
  end

  // pin level registers are read only, writes only take their time
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_func_r <= {AMPA_FUNC_NUM{AMPA_PIN_FUNC_RESET}};
      ctrl_r     <= AMPA_CTRL_RESET;
    end
    else if (finish_w && tgt_wr_r)
    begin
      if (tgt_kind_r == AMPA_TGT_FUNC)
        pin_func_r[tgt_idx_r[0]] <= wdata_r;
      if (tgt_kind_r == AMPA_TGT_CTRL)
        ctrl_r <= wdata_r;
    end
  end

  // a new error beats a write-one clear in the same cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      stat_r <= AMPA_STAT_RESET;
    else if (err_set_w)
      stat_r[AMPA_STAT_ERR_BIT] <= 1'b1;
    else if (err_clr_w)
      stat_r[AMPA_STAT_ERR_BIT] <= 1'b0;
  end

  logic pin_long_rd_w;
  logic short_acc_w;
  assign pin_long_rd_w = take_w && !err_set_w && (|pin_hit_w) && !short_w && !cpu_wr_in;
  assign short_acc_w   = take_w && !err_set_w && reg_hit_w && short_w && !rom_hit_w && !ram_hit_w;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // every take ends in exactly one answer pulse
  a_every_answer: assert property (take_w |-> ##[1:22] (cpu_done_out || cpu_err_out))
    else $error("request got no answer");
  a_done_alone: assert property (cpu_done_out |-> !cpu_err_out)
    else $error("done and error together");

  // memory hits answer in the cycle after the take
  a_rom_top_hit: assert property ((take_w && cpu_addr_in == AMPA_ADDR_TOP && ctrl_r[AMPA_CTRL_ROM_EN_BIT]
    && !cpu_wr_in) |=> (cpu_done_out && rom_sel_out))
    else $error("top address did not hit rom");
  a_ram_zero_hit: assert property ((take_w && cpu_addr_in == AMPA_ADDR_BOTTOM && ctrl_r[AMPA_CTRL_RAM_EN_BIT]
    && AMPA_RAM_LIMIT[ram_cap_sel_in] != 32'h0000_0000) |=> (ram_sel_out && mem_offset_out == 32'h0000_0000))
    else $error("address zero did not hit ram");
  a_fetch_same: assert property ((take_w && cpu_fetch_in && ram_hit_w && !rom_area_w) |=> ram_sel_out)
    else $error("fetch decoded differently");
  a_mem_one_cycle: assert property ((take_w && !err_set_w && (rom_hit_w || ram_hit_w))
    |=> (cpu_done_out && !cpu_busy_out && (rom_sel_out || ram_sel_out)))
    else $error("memory hit not answered in one cycle");

  // a refused access sets the status error bit and must leave every other register as it was
  a_disabled_err: assert property ((take_w && rom_area_w && !ctrl_r[AMPA_CTRL_ROM_EN_BIT]) |=> cpu_err_out)
    else $error("disabled rom answered");
  a_refused_clean: assert property ((take_w && err_set_w)
    |=> (cpu_err_out && !cpu_done_out && !cpu_busy_out))
    else $error("refused access went ahead");
  a_refused_kept: assert property ((take_w && err_set_w) |=> $stable(pin_func_out))
    else $error("refused access changed a function select");
  a_wide_err: assert property ((take_w && (|pin_hit_w) && cpu_size_in != AMPA_SIZE_BYTE)
    |=> (cpu_err_out && !cpu_busy_out))
    else $error("wide pin level access not refused");
  a_write_no_data: assert property ((finish_w && tgt_wr_r) |=> (cpu_done_out && cpu_rdata_out == 8'h00))
    else $error("write answered with data");

  // core-slower timing counts core cycles, the take edge being the first
  a_core_read_time: assert property ((pin_long_rd_w && peri_div_in == 3'h0)
    |=> !cpu_done_out [*2] ##1 cpu_done_out)
    else $error("pin read not three core cycles");
  a_core_write_time: assert property ((take_w && !err_set_w && (|pin_hit_w) && !short_w && cpu_wr_in
    && peri_div_in == 3'h0) |=> !cpu_done_out ##1 cpu_done_out)
    else $error("pin write not two core cycles");
  a_short_time: assert property ((short_acc_w && peri_div_in == 3'h0)
    |=> cpu_busy_out ##1 (cpu_done_out && !cpu_busy_out))
    else $error("short register access not two core cycles");

  // peripheral timing depends on the divider phase at the take edge
  a_peri_read_time: assert property ((pin_long_rd_w && peri_div_in != 3'h0)
    |=> !cpu_done_out [*2] ##[1:14] cpu_done_out)
    else $error("pin read outside peripheral tick window");
  a_short_peri_time: assert property ((short_acc_w && peri_div_in != 3'h0)
    |=> cpu_busy_out ##[0:7] (cpu_done_out && !cpu_busy_out))
    else $error("short register access outside peripheral tick window");
endmodule

// [logic/ampa_pkg.sv]
/*
  Constants and types for the address map and port access bridge.
  Assumes a single 200 MHz core clock; the peripheral rate is an enable pulse.
*/
package ampa_pkg;
  localparam int          AMPA_PORT_NUM        = 18;
  localparam int          AMPA_FUNC_NUM        = 2;
  localparam int          AMPA_SHORT_FIRST     = 16;
  localparam logic [31:0] AMPA_ADDR_BOTTOM     = 32'h0000_0000;
  localparam logic [31:0] AMPA_ADDR_TOP        = 32'hFFFF_FFFF;
  // rom start per capacity select: 1M, 768K, 512K, 384K, 256K, 128K, 96K, 64K
  localparam logic [31:0] AMPA_ROM_BASE [8]    = '{32'hFFF0_0000, 32'hFFF4_0000, 32'hFFF8_0000, 32'hFFFA_0000,
                                                   32'hFFFC_0000, 32'hFFFE_0000, 32'hFFFE_8000, 32'hFFFF_0000};
  // ram end, exclusive, per select: 96K, 64K, 32K, 20K, 16K, 12K; zero means no ram
  localparam logic [31:0] AMPA_RAM_LIMIT [8]   = '{32'h0001_8000, 32'h0001_0000, 32'h0000_8000, 32'h0000_5000,
                                                   32'h0000_4000, 32'h0000_3000, 32'h0000_0000, 32'h0000_0000};
  // pin level bytes, ports 2..9, a..f, h, j, k, l
  localparam logic [31:0] AMPA_PIN_LEVEL_ADDR [AMPA_PORT_NUM] = '{
    32'h0008_C042, 32'h0008_C043, 32'h0008_C044, 32'h0008_C045, 32'h0008_C046, 32'h0008_C047,
    32'h0008_C048, 32'h0008_C049, 32'h0008_C04A, 32'h0008_C04B, 32'h0008_C04C, 32'h0008_C04D,
    32'h0008_C04E, 32'h0008_C04F, 32'h0008_C051, 32'h0008_C052, 32'h0008_C053, 32'h0008_C054};
  localparam logic [31:0] AMPA_PIN_FUNC_ADDR [AMPA_FUNC_NUM]  = '{32'h0008_C060, 32'h0008_C061};
  localparam logic [31:0] AMPA_CTRL_ADDR       = 32'h0008_C0F0;
  localparam logic [31:0] AMPA_STAT_ADDR       = 32'h0008_C0F1;
  localparam int          AMPA_CTRL_ROM_EN_BIT = 0;
  localparam int          AMPA_CTRL_RAM_EN_BIT = 1;
  localparam int          AMPA_STAT_ERR_BIT    = 0;
  localparam logic [7:0]  AMPA_CTRL_RESET      = 8'h03;
  localparam logic [7:0]  AMPA_STAT_RESET      = 8'h00;
  localparam logic [7:0]  AMPA_PIN_FUNC_RESET  = 8'h00;
  localparam logic [1:0]  AMPA_SIZE_BYTE       = 2'h0;
  localparam logic [1:0]  AMPA_SIZE_WORD       = 2'h1;
  localparam logic [1:0]  AMPA_SIZE_LONG       = 2'h2;
  localparam logic [2:0]  AMPA_PIN_RD_CYC      = 3'h3;
  localparam logic [2:0]  AMPA_PIN_WR_CYC      = 3'h2;
  localparam logic [2:0]  AMPA_SHORT_CYC       = 3'h2;
  localparam logic [1:0]  AMPA_TGT_PIN         = 2'h0;
  localparam logic [1:0]  AMPA_TGT_FUNC        = 2'h1;
  localparam logic [1:0]  AMPA_TGT_CTRL        = 2'h2;
  localparam logic [1:0]  AMPA_TGT_STAT        = 2'h3;
  typedef enum logic [1:0] {AMPA_MODE_SINGLE, AMPA_MODE_BOOT, AMPA_MODE_USER_BOOT} ampa_mode_t;
  typedef enum logic {AMPA_IDLE, AMPA_WAIT} ampa_state_t;
endpackage
